// ==== gpt_pkg.sv ====
/*
  Shared constants and types of the general purpose timer block: register
  byte offsets, field positions, mode and event codes, reset values.
  Assumes nothing of its surroundings; gpt_edge, gpt_top and the bench import it.
*/
package gpt_pkg;

  // Byte address width of the register window.
  localparam int         ADDR_W    = 7;

  // Register byte offsets; each register is one aligned word.
  localparam logic [6:0] OFS_CFG   = 7'h00;
  localparam logic [6:0] OFS_AMR   = 7'h04;
  localparam logic [6:0] OFS_BMR   = 7'h08;
  localparam logic [6:0] OFS_CTL   = 7'h0c;
  localparam logic [6:0] OFS_IMR   = 7'h18;
  localparam logic [6:0] OFS_RIS   = 7'h1c;
  localparam logic [6:0] OFS_MIS   = 7'h20;
  localparam logic [6:0] OFS_ICR   = 7'h24;
  localparam logic [6:0] OFS_ILR_A = 7'h28;
  localparam logic [6:0] OFS_ILR_B = 7'h2c;
  localparam logic [6:0] OFS_MAT_A = 7'h30;
  localparam logic [6:0] OFS_MAT_B = 7'h34;
  localparam logic [6:0] OFS_PR_A  = 7'h38;
  localparam logic [6:0] OFS_PR_B  = 7'h3c;
  localparam logic [6:0] OFS_PMR_A = 7'h40;
  localparam logic [6:0] OFS_PMR_B = 7'h44;
  localparam logic [6:0] OFS_TV_A  = 7'h48;
  localparam logic [6:0] OFS_TV_B  = 7'h4c;

  // Module arrangement codes; bit 2 set means two 16-bit halves.
  localparam logic [2:0] CFG_32    = 3'h0;
  localparam logic [2:0] CFG_RTC   = 3'h1;
  localparam int         CFG_16    = 2;

  // Mode register fields.
  localparam int         MR_CMR    = 2;
  localparam int         MR_AMS    = 3;
  localparam logic [1:0] MR_ONE    = 2'h1;
  localparam logic [1:0] MR_PER    = 2'h2;
  localparam logic [1:0] MR_CAP    = 2'h3;

  // Control register fields; half B sits one step above half A.
  localparam int          CTL_STEP  = 8;
  localparam int          CTL_EN    = 0;
  localparam int          CTL_EVT   = 2;
  localparam int          CTL_INV   = 6;
  localparam logic [15:0] CTL_MASK  = 16'h6f7f;
  localparam logic [1:0]  EVT_RISE  = 2'h0;
  localparam logic [1:0]  EVT_FALL  = 2'h1;
  localparam logic [1:0]  EVT_BOTH  = 2'h3;

  // Interrupt bit positions, shared by mask, raw, masked and clear.
  localparam int          INT_STEP  = 8;
  localparam int          INT_TO    = 0;
  localparam int          INT_CM    = 1;
  localparam int          INT_CE    = 2;
  localparam int          INT_RTC   = 3;
  localparam logic [10:0] INT_MASK  = 11'h70f;

  // Reset values.
  localparam logic [15:0] RST_HALF  = 16'hffff;
  localparam logic [15:0] RST_ZERO  = 16'h0000;

  // Decoded behaviour of one half.
  typedef enum logic [2:0] {
    MD_OFF = 3'b000,
    MD_ONE = 3'b001,
    MD_PER = 3'b010,
    MD_CNT = 3'b011,
    MD_TIM = 3'b100,
    MD_PWM = 3'b101
  } gpt_mode_type;

endpackage

// ==== gpt_edge_if.sv ====
/*
  Carrier between the timer core and one edge detector: raw pin, edge
  selection and the detected event pulse.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface gpt_edge_if;
  logic       pin;  // Raw pin level, asynchronous to the clock.
  logic [1:0] sel;  // Selected edge type.
  logic       hit;  // One-cycle pulse per selected edge.
  modport det  (input pin, input sel, output hit);
  modport core (output pin, output sel, input hit);
endinterface

// ==== gpt_edge.sv ====
/*
  Synchroniser and edge selector for one capture pin.
  Assumes the pin is asynchronous and the selection is on the clock.
*/
`timescale 1ns/1ps
module gpt_edge (
  input wire logic clk,
  input wire logic rst,
  gpt_edge_if.det  port
);
  import gpt_pkg::*;

  // Two-stage synchroniser, a history stage and the event flop.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic hit;
  } gpt_edge_state_type;

  gpt_edge_state_type st;       // Registered state.
  gpt_edge_state_type next_st;  // Next state.

  // Only the second stage and its history are compared, never s1.
  always_comb begin
    next_st    = st;
    next_st.s1 = port.pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    case (port.sel)
      EVT_RISE: next_st.hit = st.s2 & ~st.s3;  // see RQ23
      EVT_FALL: next_st.hit = ~st.s2 & st.s3;  // see RQ23
      EVT_BOTH: next_st.hit = st.s2 ^ st.s3;   // see RQ23
      default:  next_st.hit = 1'b0;            // Reserved code.
    endcase
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.hit = st.hit;

endmodule

// ==== gpt_top.sv ====
/*
  General purpose timer with two 16-bit halves, an Avalon-MM register
  slave with waitrequest, capture pins and one interrupt line.
  Assumes one clock; pins are asynchronous and are synchronised here.
*/
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// RQ1: Software disables a half before reconfiguring it.
// RQ2: Configuration selects 32-bit, clock counter, split.
// RQ3: Mode 1 is one-shot, mode 2 periodic.
// RQ4: Periodic keeps counting, one-shot stops.
// RQ5: Run bit starts counting or capture.
// RQ6: Time-out raw flag holds until cleared.
// RQ7: Time-out interrupt only when mask set.
// RQ8: Clock counter advances on reference pin.
// RQ9: Clock counter reloads zero on match.
// RQ10: Clock counter match masked, counter keeps running.
// RQ11: Capture type 0, mode 3: edge count.
// RQ12: Capture type 1, mode 3: edge timing.
// RQ13: Capture reacts only to selected edge.
// RQ14: Edge count stops at programmed count.
// RQ15: Count target sets capture-match flag.
// RQ16: Edge timing latches count, keeps counting.
// RQ17: Captured edge sets capture-event flag.
// RQ18: Load write applies next cycle, no stop; here only in edge timing and waveform modes.
// RQ19: Alternate 1, capture 0, mode 2: waveform.
// RQ20: Waveform polarity is software selectable.
// RQ21: Prescaler extends waveform, runs until disabled.
// RQ22: Half A values reset by arrangement width.
// RQ23: Edge codes: rise, fall, both, reserved.
// RQ24: One-shot reloads, stops, clears run bit.
// RQ25: Waveform sets at load, clears at match.
// RQ26: Masked status is AND; line ORs them.
// RQ27: 32-bit arrangements chain halves under A.
module gpt_top (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [gpt_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output wire logic [31:0]                avs_readdata,
  output wire logic                       avs_waitrequest,
  input  wire logic [1:0]                 cc_pin_in,
  output wire logic [1:0]                 cc_pin_out,
  output wire logic [1:0]                 cc_pin_oe,
  output wire logic                       irq
);
  import gpt_pkg::*;

  // Every flip-flop of the block outside the edge detectors.
  typedef struct packed {
    logic [2:0]       cfg;      // Module arrangement.
    logic [1:0][3:0]  mr;       // Mode register per half.
    logic [15:0]      ctl;      // Control register.
    logic [10:0]      imr;      // Interrupt mask.
    logic [10:0]      ris;      // Raw interrupt status.
    logic [1:0][15:0] ilr;      // Interval load, low half.
    logic [15:0]      ilr_hi;   // Interval load, upper half of A.
    logic [1:0][15:0] mat;      // Match, low half.
    logic [15:0]      mat_hi;   // Match, upper half of A.
    logic [1:0][7:0]  pr;       // Prescale.
    logic [1:0][7:0]  pmr;      // Prescale match.
    logic [1:0][15:0] cnt;      // Counters; chained in 32-bit use.
    logic [1:0][7:0]  pre;      // Prescale counters.
    logic [1:0][15:0] cap;      // Captured edge times.
    logic [1:0]       lvl;      // Waveform level before inversion.
    logic [1:0]       pin_out;  // Pin drive value.
    logic [1:0]       pin_oe;   // Pin drive enable.
    logic             irq;      // Interrupt line.
    logic             waitreq;  // Bus wait, high while idle.
    logic [31:0]      rdata;    // Read data held for the master.
  } gpt_regs_type;

  gpt_regs_type st;       // Registered state.
  gpt_regs_type next_st;  // Next state.

  logic [1:0]   hit;      // Edge events from the detectors.
  logic         rd_go;    // First cycle of a bus request.
  logic         wr_ok;    // Write takes effect on this edge.
  logic [31:0]  w;        // Addressed register merged with write data.
  logic [10:0]  clr;      // Clear requests from software.
  logic [10:0]  set;      // Events raised this cycle.
  logic [1:0]   ilr_wr;   // Interval load written this cycle.
  logic [31:0]  c32;      // Chained counter.
  logic [31:0]  ld32;     // Chained load value.
  gpt_mode_type md;       // Decoded mode of the half in work.
  logic         en;       // Run bit of the half in work.
  logic [15:0]  c;        // Counter of the half in work.
  logic [7:0]   p;        // Prescale counter of the half in work.
  logic         lv;       // Waveform level of the half in work.

  // Decodes the mode field of one half, or of half A in 32-bit use.
  function automatic gpt_mode_type half_mode(input logic [3:0] m);
    gpt_mode_type r;
    r = MD_OFF;
    if (m[1:0] == MR_ONE) begin
      r = MD_ONE;  // see RQ3
    end else if (m[1:0] == MR_PER) begin
      // Waveform needs alternate set and capture type clear.
      r = (m[MR_AMS] && !m[MR_CMR]) ? MD_PWM : MD_PER;  // see RQ19
    end else if (m[1:0] == MR_CAP) begin
      r = m[MR_CMR] ? MD_TIM : MD_CNT;  // see RQ11, see RQ12
    end
    return r;
  endfunction

  // Read value of a register; unmapped offsets read as zero.
  function automatic logic [31:0] read_reg(input gpt_regs_type s,
                                           input logic [6:0]   a);
    logic        wide;
    logic [31:0] r;
    wide = !s.cfg[CFG_16];
    r    = '0;
    case (a)
      OFS_CFG:   r = 32'(s.cfg);
      OFS_AMR:   r = 32'(s.mr[0]);
      OFS_BMR:   r = 32'(s.mr[1]);
      OFS_CTL:   r = 32'(s.ctl);
      OFS_IMR:   r = 32'(s.imr);
      OFS_RIS:   r = 32'(s.ris);
      OFS_MIS:   r = 32'(s.ris & s.imr);  // see RQ26
      // Upper half of A shows only in 32-bit use.
      OFS_ILR_A: r = {wide ? s.ilr_hi : RST_ZERO, s.ilr[0]};  // see RQ22
      OFS_ILR_B: r = 32'(s.ilr[1]);
      OFS_MAT_A: r = {wide ? s.mat_hi : RST_ZERO, s.mat[0]};  // see RQ22
      OFS_MAT_B: r = 32'(s.mat[1]);
      OFS_PR_A:  r = 32'(s.pr[0]);
      OFS_PR_B:  r = 32'(s.pr[1]);
      OFS_PMR_A: r = 32'(s.pmr[0]);
      OFS_PMR_B: r = 32'(s.pmr[1]);
      OFS_TV_A: begin
        if (wide) begin
          r = {s.cnt[1], s.cnt[0]};  // see RQ22
        end else if (half_mode(s.mr[0]) == MD_TIM) begin
          r = 32'(s.cap[0]);  // see RQ16
        end else begin
          r = 32'(s.cnt[0]);
        end
      end
      OFS_TV_B: begin
        if (!wide && half_mode(s.mr[1]) == MD_TIM) begin
          r = 32'(s.cap[1]);  // see RQ16
        end else begin
          r = 32'(s.cnt[1]);
        end
      end
      default:   r = '0;
    endcase
    return r;
  endfunction

  // Byte lanes with their enable take write data, the rest keep old.
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable[b]) begin
        r[b*8 +: 8] = avs_writedata[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // One edge detector per capture pin.
  gpt_edge_if eif [2] ();

  generate
    for (genvar g = 0; g < 2; g++) begin : g_pin
      assign eif[g].pin = cc_pin_in[g];
      // The clock counter always counts rising reference edges.
      assign eif[g].sel = (g == 0 && st.cfg == CFG_RTC) ? EVT_RISE :
                          st.ctl[g*CTL_STEP+CTL_EVT +: 2];  // see RQ13
      assign hit[g]     = eif[g].hit;
      gpt_edge u_edge (
        .clk  (clk),
        .rst  (rst),
        .port (eif[g])
      );
    end
  endgenerate

  // Bus slave, configuration, counting and status in one next state.
  always_comb begin
    next_st = st;
    set     = '0;
    ilr_wr  = '0;
    md      = MD_OFF;
    en      = 1'b0;
    c       = '0;
    p       = '0;
    lv      = 1'b0;

    // A request waits one cycle, then stands with waitrequest low.
    rd_go   = (avs_read || avs_write) && st.waitreq;
    wr_ok   = avs_write && !st.waitreq;
    next_st.waitreq = !rd_go;
    if (rd_go) begin
      next_st.rdata = read_reg(st, avs_address);
    end

    // Register writes; clear reads as zero so merging yields the mask.
    w   = merge(read_reg(st, avs_address));
    clr = '0;
    if (wr_ok) begin
      case (avs_address)
        OFS_CFG:   next_st.cfg = w[2:0];
        OFS_AMR:   next_st.mr[0] = w[3:0];
        OFS_BMR:   next_st.mr[1] = w[3:0];
        OFS_CTL:   next_st.ctl = w[15:0] & CTL_MASK;  // see RQ5
        OFS_IMR:   next_st.imr = w[10:0] & INT_MASK;
        OFS_ICR:   clr = w[10:0] & INT_MASK;
        OFS_ILR_A: begin
          {next_st.ilr_hi, next_st.ilr[0]} = w;
          ilr_wr[0] = 1'b1;
        end
        OFS_ILR_B: begin
          next_st.ilr[1] = w[15:0];
          ilr_wr[1] = 1'b1;
        end
        OFS_MAT_A: {next_st.mat_hi, next_st.mat[0]} = w;
        OFS_MAT_B: next_st.mat[1] = w[15:0];
        OFS_PR_A:  next_st.pr[0] = w[7:0];
        OFS_PR_B:  next_st.pr[1] = w[7:0];
        OFS_PMR_A: next_st.pmr[0] = w[7:0];
        OFS_PMR_B: next_st.pmr[1] = w[7:0];
        default:   ;
      endcase
    end

    // Counting follows the configuration as it stands after the write.
    c32  = {st.cnt[1], st.cnt[0]};
    ld32 = {next_st.ilr_hi, next_st.ilr[0]};
    en   = next_st.ctl[CTL_EN];
    if (next_st.cfg == CFG_32) begin  // see RQ2
      // Both halves chained, steered by half A only.
      md = half_mode(next_st.mr[0]);  // see RQ27
      if (!en || (md != MD_ONE && md != MD_PER)) begin
        c32 = ld32;  // Preload while stopped.
      end else if (c32 == '0) begin
        c32 = ld32;
        set[INT_TO] = 1'b1;  // see RQ6
        if (md == MD_ONE) begin
          next_st.ctl[CTL_EN] = 1'b0;  // see RQ4, see RQ24
        end
      end else begin
        c32 = c32 - 32'h00000001;  // see RQ5
      end
      next_st.cnt = c32;
    end else if (next_st.cfg == CFG_RTC) begin
      // Counts reference edges upward; a match restarts it at zero.
      if (!en) begin
        c32 = '0;
      end else if (hit[0]) begin  // see RQ8
        if (c32 == {next_st.mat_hi, next_st.mat[0]}) begin
          c32 = '0;  // see RQ9
          set[INT_RTC] = 1'b1;  // see RQ10
        end else begin
          c32 = c32 + 32'h00000001;
        end
      end
      next_st.cnt = c32;
    end else if (next_st.cfg[CFG_16]) begin
      // Two independent halves.
      for (int h = 0; h < 2; h++) begin
        md = half_mode(next_st.mr[h]);
        en = next_st.ctl[h*CTL_STEP+CTL_EN];
        c  = st.cnt[h];
        p  = st.pre[h];
        lv = st.lvl[h];
        if (!en || md == MD_OFF) begin
          // Stopped halves preload so a start counts from the load.
          c  = next_st.ilr[h];
          p  = next_st.pr[h];
          lv = 1'b0;
        end else begin
          unique case (md)
            MD_ONE, MD_PER, MD_PWM: begin
              // The prescaler divides by its value plus one.
              if (p != 8'h00) begin
                p = p - 8'h01;  // see RQ21
              end else begin
                p = next_st.pr[h];
                if (c == 16'h0000) begin
                  c = next_st.ilr[h];  // see RQ4
                  if (md != MD_PWM) begin
                    set[h*INT_STEP+INT_TO] = 1'b1;  // see RQ6
                  end
                  if (md == MD_ONE) begin
                    next_st.ctl[h*CTL_STEP+CTL_EN] = 1'b0;  // see RQ24
                  end
                end else begin
                  c = c - 16'h0001;
                end
              end
            end
            MD_CNT: begin
              if (hit[h]) begin
                if (c - 16'h0001 == next_st.mat[h]) begin
                  // Target reached: reload and ignore later edges.
                  c = next_st.ilr[h];  // see RQ14
                  set[h*INT_STEP+INT_CM] = 1'b1;  // see RQ15
                  next_st.ctl[h*CTL_STEP+CTL_EN] = 1'b0;  // see RQ14
                end else begin
                  c = c - 16'h0001;
                end
              end
            end
            MD_TIM: begin
              if (hit[h]) begin
                next_st.cap[h] = c;  // see RQ16
                set[h*INT_STEP+INT_CE] = 1'b1;  // see RQ17
              end
              c = (c == 16'h0000) ? next_st.ilr[h] : c - 16'h0001;
            end
            default: ;
          endcase
          // In edge timing and waveform modes a new load takes over at once without stopping the count.
          if (ilr_wr[h] && (md == MD_TIM || md == MD_PWM)) begin
            c = next_st.ilr[h];  // see RQ18
          end
          // Set at the start value, cleared at the match value.
          if (md == MD_PWM) begin
            if (c == next_st.ilr[h]) begin
              lv = 1'b1;  // see RQ25
            end else if ({p, c} == {next_st.pmr[h], next_st.mat[h]}) begin
              lv = 1'b0;  // see RQ25, see RQ21
            end
          end
        end
        next_st.cnt[h]  = c;
        next_st.pre[h]  = p;
        next_st.lvl[h]  = lv;
        next_st.pin_oe[h]  = (md == MD_PWM);  // see RQ19
        next_st.pin_out[h] = (md == MD_PWM) &&
          (lv ^ next_st.ctl[h*CTL_STEP+CTL_INV]);  // see RQ20
      end
    end

    // In 32-bit use the pins are inputs only.
    if (!next_st.cfg[CFG_16]) begin
      next_st.pin_oe  = '0;
      next_st.pin_out = '0;
      next_st.lvl     = '0;
    end

    // A flag raised in the cycle of its clear stays set.
    next_st.ris = (st.ris & ~clr) | set;  // see RQ6, see RQ15, see RQ17
    next_st.irq = |(next_st.ris & next_st.imr);  // see RQ7, see RQ26
  end

  // State register; the 32-bit arrangement is the reset arrangement.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st         <= '0;
      st.ilr     <= {RST_HALF, RST_HALF};  // see RQ22
      st.ilr_hi  <= RST_HALF;
      st.mat     <= {RST_HALF, RST_HALF};
      st.mat_hi  <= RST_HALF;
      st.cnt     <= {RST_HALF, RST_HALF};
      st.cap     <= {RST_HALF, RST_HALF};
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign cc_pin_out      = st.pin_out;
  assign cc_pin_oe       = st.pin_oe;
  assign irq             = st.irq;

endmodule

// ==== gpt_monitor.sv ====
/*
  Port checker for the general purpose timer.
  Assumes it is bound to gpt_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module gpt_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  cc_pin_out,
  input wire logic [1:0]  cc_pin_oe,
  input wire logic        irq
);
  // One clock domain, so the clock and reset are given once here.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A taken request sees exactly one wait cycle.
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Wait state not exactly one cycle.");
  // The answer stands for one cycle only.
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle.");
  // No answer without a request.
  wait_cause_a: assert property (
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("Answer without a request.");
  // An idle bus keeps waitrequest high.
  idle_wait_a: assert property (
    !(avs_read || avs_write) |-> avs_waitrequest)
    else $error("Waitrequest low while idle.");
  // Read data change only where a request is taken.
  rdata_hold_a: assert property ($changed(avs_readdata)
    |-> $past((avs_read || avs_write) && avs_waitrequest))
    else $error("Read data changed outside a request.");
  // A raised line falls only after a register write completes.
  irq_fall_a: assert property (
    $fell(irq) |-> $past(avs_write && !avs_waitrequest))
    else $error("Interrupt line fell without a write.");
  // Waveform mode, and so the pin enable, follows register writes.
  oe_cause_a: assert property (
    $changed(cc_pin_oe) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("Pin enable changed without a write.");
  // A pin level moves only while its half drives a waveform.
  out_a_a: assert property (
    $changed(cc_pin_out[0]) |-> cc_pin_oe[0] || $past(cc_pin_oe[0]))
    else $error("Pin zero moved outside waveform mode.");
  out_b_a: assert property (
    $changed(cc_pin_out[1]) |-> cc_pin_oe[1] || $past(cc_pin_oe[1]))
    else $error("Pin one moved outside waveform mode.");
  // Main scenarios.
  cover property (avs_write && !avs_waitrequest);
  cover property ($rose(irq));
  cover property ($rose(cc_pin_out[0]));
endmodule

bind gpt_top gpt_monitor mon (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .irq(irq));

// ==== gpt_pins.sv ====
/*
  Model of the capture pins and the reference clock source.
  Assumes the bench calls pulse and sets ref_on only when the
  reference is needed, after the last pulse on pin zero.
*/
`timescale 1ns/1ps
module gpt_pins (
  input  wire logic       clk,
  input  wire logic       ref_on,
  output logic      [1:0] pin
);
  int cnt;  // Divider for the scaled reference clock.
  initial pin = 2'h0;
  initial cnt = 0;
  // Scaled reference: 16 clocks a period keeps the run short.
  always @(posedge clk) begin
    if (ref_on) begin
      cnt <= (cnt == 7) ? 0 : cnt + 1;
      if (cnt == 7) pin[0] <= ~pin[0];
    end
  end
  // Pulses of 4 high and 4 low, above the 2 and 2 the sampler needs.
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk);
      pin[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      pin[ch] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ==== gpt_top_bench.sv ====
/*
  Self-checking bench for the timer: register tasks and scenarios.
  Assumes gpt_pins models the pins and gpt_monitor is bound to the top.
*/
`timescale 1ns/1ps
module gpt_top_bench;
  import gpt_pkg::*;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, irq, ref_on;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, q2, ctl;
  logic [3:0]  avs_byteenable;
  logic [1:0]  cc_pin_in, cc_pin_out, cc_pin_oe;
  int          error_cnt, compares, hi;
  logic [1:0]  evt [4] = '{EVT_RISE, EVT_FALL, EVT_BOTH, 2'h2};
  int          np  [4] = '{5, 4, 2, 4};
  logic [31:0] fl  [4] = '{32'h2, 32'h2, 32'h2, 32'h0};

  gpt_top dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .irq(irq));
  gpt_pins pins (.clk(clk), .ref_on(ref_on), .pin(cc_pin_in));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One bus access; held until waitrequest is seen low at an edge.
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    acc(1'b1, a, d, q2);
  endtask

  task automatic chk(input logic [6:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask

  // Counts high cycles of pin zero over c cycles, starting 25 cycles after the call.
  task automatic hcount(input int c);
    repeat (25) @(posedge clk);
    hi = 0;
    repeat (c) begin
      @(negedge clk);
      if (cc_pin_out[0] === 1'b1) hi++;
    end
  endtask

  // A hang is cut short long after the tests should be over.
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    {rst, avs_read, avs_write, ref_on} = 4'h8;
    {avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk(OFS_CFG, 32'h0);
    chk(OFS_ILR_A, 32'hffffffff);
    chk(OFS_MAT_A, 32'hffffffff);
    chk(OFS_TV_A, 32'hffffffff);
    chk(OFS_ILR_B, 32'h0000ffff);
    wr(OFS_RIS, 32'h0000070f);
    chk(OFS_RIS, 32'h0);
    wr(7'h50, 32'h1);
    chk(7'h50, 32'h0);
    wr(OFS_CFG, 32'h4);
    chk(OFS_ILR_A, 32'h0000ffff);
    $display("test reset done");
    // 32-bit one-shot; the half is idle, so no disable is needed.
    wr(OFS_CFG, 32'h0);
    wr(OFS_AMR, 32'h1);
    wr(OFS_ILR_A, 32'h14);
    wr(OFS_IMR, 32'h1);
    wr(OFS_CTL, 32'h1);
    repeat (40) @(posedge clk);
    @(negedge clk);
    cmp(32'(irq), 32'h1);
    chk(OFS_RIS, 32'h1);
    chk(OFS_MIS, 32'h1);
    chk(OFS_CTL, 32'h0);
    chk(OFS_TV_A, 32'h14);
    wr(OFS_ICR, 32'h1);
    chk(OFS_RIS, 32'h0);
    repeat (60) @(posedge clk);
    chk(OFS_RIS, 32'h0);
    $display("test one-shot done");
    // Split periodic half B with its mask clear.
    wr(OFS_CFG, 32'h4);
    wr(OFS_BMR, 32'h2);
    wr(OFS_ILR_B, 32'ha);
    wr(OFS_IMR, 32'h0);
    wr(OFS_CTL, 32'h100);
    repeat (40) @(posedge clk);
    @(negedge clk);
    cmp(32'(irq), 32'h0);
    chk(OFS_RIS, 32'h100);
    chk(OFS_MIS, 32'h0);
    wr(OFS_ICR, 32'h100);
    repeat (30) @(posedge clk);
    chk(OFS_RIS, 32'h100);
    chk(OFS_CTL, 32'h100);
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'h100);
    $display("test periodic done");
    // Edge count on half A for every event code; 10 gives nothing.
    wr(OFS_AMR, 32'h3);
    wr(OFS_IMR, 32'h2);
    for (int k = 0; k < 4; k++) begin
      ctl = {28'h0, evt[k], 2'h0};
      wr(OFS_CTL, 32'h0);
      wr(OFS_ICR, 32'h2);
      wr(OFS_CTL, ctl);
      wr(OFS_ILR_A, 32'ha);
      wr(OFS_MAT_A, 32'h6);
      wr(OFS_CTL, ctl | 32'h1);
      pins.pulse(0, np[k]);
      repeat (8) @(posedge clk);
      chk(OFS_RIS, fl[k]);
      chk(OFS_CTL, ctl | 32'(fl[k] == 32'h0));
      chk(OFS_TV_A, 32'ha);
    end
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'h2);
    $display("test edge count done");
    // Edge timing on half B: latch, keep counting, live reload.
    wr(OFS_BMR, 32'h7);
    wr(OFS_IMR, 32'h400);
    wr(OFS_ILR_B, 32'hffff);
    wr(OFS_CTL, 32'h100);
    pins.pulse(1, 1);
    repeat (8) @(posedge clk);
    @(negedge clk);
    cmp(32'(irq), 32'h1);
    chk(OFS_RIS, 32'h400);
    acc(1'b0, OFS_TV_B, 32'h0, ctl);
    repeat (20) @(posedge clk);
    chk(OFS_TV_B, ctl);
    cmp(32'(ctl > 32'hff00 && ctl < 32'hffff), 32'h1);
    wr(OFS_ICR, 32'h400);
    wr(OFS_ILR_B, 32'h40);
    pins.pulse(1, 1);
    repeat (8) @(posedge clk);
    acc(1'b0, OFS_TV_B, 32'h0, ctl);
    cmp(32'(ctl <= 32'h40), 32'h1);
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'h400);
    $display("test edge timing done");
    // Waveform on half A: duty, inversion, prescaler.
    wr(OFS_AMR, 32'ha);
    wr(OFS_ILR_A, 32'h14);
    wr(OFS_MAT_A, 32'ha);
    wr(OFS_CTL, 32'h1);
    cmp(32'(cc_pin_oe[0]), 32'h1);
    hcount(42);
    cmp(hi, 20);
    wr(OFS_CTL, 32'h0);
    wr(OFS_CTL, 32'h41);
    hcount(42);
    cmp(hi, 22);
    wr(OFS_CTL, 32'h0);
    wr(OFS_PR_A, 32'h1);
    wr(OFS_CTL, 32'h1);
    hcount(84);
    cmp(hi, 42);
    wr(OFS_CTL, 32'h0);
    $display("test waveform done");
    // Clock counter on the reference pin, interrupt left pending.
    wr(OFS_CFG, 32'h1);
    wr(OFS_MAT_A, 32'h3);
    wr(OFS_IMR, 32'h8);
    ref_on <= 1'b1;
    wr(OFS_CTL, 32'h11);
    repeat (150) @(posedge clk);
    @(negedge clk);
    cmp(32'(irq), 32'h1);
    chk(OFS_RIS, 32'h8);
    acc(1'b0, OFS_TV_A, 32'h0, ctl);
    cmp(32'(ctl <= 32'h3), 32'h1);
    repeat (40) @(posedge clk);
    acc(1'b0, OFS_TV_A, 32'h0, q);
    cmp(32'(q !== ctl), 32'h1);
    $display("test clock counter done");
    end_sim();
  end
endmodule
